// >>> design/apf_pkg.sv
package apf_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] APF_ADDR_IN_FMT = 8'h14;
    localparam logic [7:0] APF_ADDR_RATE = 8'h15;
    localparam logic [7:0] APF_ADDR_DET_STATUS = 8'h18;
    localparam logic [7:0] APF_ADDR_TX_MODE = 8'h1A;
    localparam logic [7:0] APF_ADDR_OUT_FMT = 8'h44;
    localparam logic [7:0] APF_ADDR_RX_MODE = 8'h4A;

    // ------------------------------------------------------------
    // Reset values and writable-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] APF_RST_TX_MODE = 8'h00;
    localparam logic [7:0] APF_RST_IN_FMT = 8'h00;
    localparam logic [7:0] APF_RST_RATE = 8'h00;
    localparam logic [7:0] APF_RST_OUT_FMT = 8'h00;
    localparam logic [7:0] APF_RST_RX_MODE = 8'h00;
    localparam logic [7:0] APF_WMASK_IN_FMT = 8'hBF;
    localparam logic [7:0] APF_WMASK_OUT_FMT = 8'h7F;
    localparam logic [7:0] APF_WMASK_RX_MODE = 8'hB4;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int APF_TXM_REQ_POL = 4;
    localparam int APF_TXM_SPDIF = 2;
    localparam int APF_TXM_MCLK_LO = 0;
    localparam int APF_INF_DATA = 7;
    localparam int APF_RXM_PDN = 7;
    localparam int APF_RXM_EN = 5;
    localparam int APF_RXM_REQ_POL = 4;
    localparam int APF_RXM_SPDIF = 2;
    localparam int APF_OUTF_SIZE_LO = 4;
    localparam int APF_OUTF_WS_POL = 3;
    localparam int APF_OUTF_EDGE = 2;
    localparam int APF_OUTF_DELAY = 1;
    localparam int APF_OUTF_JUST = 0;
    localparam int APF_DET_ERR = 7;

    // ------------------------------------------------------------
    // Rates and timing
    // ------------------------------------------------------------
    localparam int APF_CLK_HZ = 50_000_000;
    localparam int APF_CLK_KHZ = APF_CLK_HZ / 1000;
    localparam int APF_MCLK_MULT = 256;
    localparam int APF_FS_48K = 48_000;
    localparam int APF_FS_44K1 = 44_100;
    localparam int APF_FS_32K = 32_000;
    localparam logic [10:0] APF_RATE_UNIT_KBPS = 11'h008;
    localparam logic [10:0] APF_RATE_TOP_KBPS = 11'h600;
    localparam logic [7:0] APF_RATE_TOP_CODE = 8'hBF;
    localparam int APF_PACE_STOP_BITS = 32;
    localparam int APF_BURST_BITS = 2 * APF_PACE_STOP_BITS;
    localparam int APF_CREDIT_W = 24;
    localparam logic signed [23:0] APF_BIT_COST = 24'(APF_CLK_KHZ);
    localparam logic signed [23:0] APF_CREDIT_MAX =
        24'(APF_BURST_BITS * APF_CLK_KHZ);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        APF_MCLK_OFF = 2'b00,
        APF_MCLK_48K = 2'b01,
        APF_MCLK_44K1 = 2'b10,
        APF_MCLK_32K = 2'b11
    } apf_mclk_sel_t;

    typedef enum logic [1:0] {
        APF_OUT_IDLE = 2'b00,
        APF_OUT_RUN = 2'b01,
        APF_OUT_HALT = 2'b10
    } apf_out_state_t;

    typedef struct packed {
        logic bclk;
        logic ws;
        logic data;
    } apf_ser_pins_t;

    typedef struct packed {
        logic [7:0] tx_mode;
        logic [7:0] in_fmt;
        logic [7:0] rate;
        logic [7:0] out_fmt;
        logic [7:0] rx_mode;
    } apf_regs_t;

    typedef struct packed {
        logic [31:0] acc;
        logic out;
    } apf_nco_state_t;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [10:0] apf_rate_kbps(input logic [7:0] n);
        if (n == 8'h00) begin
            return APF_RATE_UNIT_KBPS;
        end else if (n == 8'h01) begin
            return 11'(2 * APF_RATE_UNIT_KBPS);
        end else if (n < APF_RATE_TOP_CODE) begin
            return 11'((11'(n) + 11'h001) * APF_RATE_UNIT_KBPS);
        end else if (n == APF_RATE_TOP_CODE) begin
            return APF_RATE_TOP_KBPS;
        end else begin
            return 11'h000;
        end
    endfunction

    function automatic logic [31:0] apf_nco_inc(input int fs);
        return 32'(((64'(fs) * 64'(APF_MCLK_MULT)) << 32) / 64'(APF_CLK_HZ));
    endfunction

endpackage

// >>> design/apf_mclk_gen.sv
`timescale 1ns/1ns
module apf_mclk_gen (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Control
    input wire apf_pkg::apf_mclk_sel_t sel_in,
    input wire logic block_in,
    // Clock output
    output logic mclk_out
);
    import apf_pkg::*;

    apf_nco_state_t s_q;
    apf_nco_state_t s_d;
    logic [31:0] inc;

    // ------------------------------------------------------------
    // Phase accumulator; its top bit is the 256x fs clock
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        unique case (sel_in)
            APF_MCLK_48K: inc = apf_nco_inc(APF_FS_48K);
            APF_MCLK_44K1: inc = apf_nco_inc(APF_FS_44K1);
            APF_MCLK_32K: inc = apf_nco_inc(APF_FS_32K);
            APF_MCLK_OFF: inc = 32'h0000_0000;
        endcase
        s_d.acc = s_q.acc + inc;
        s_d.out = s_d.acc[31] && !block_in && (sel_in != APF_MCLK_OFF);
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign mclk_out = s_q.out;

endmodule // apf_mclk_gen

// >>> design/apf_port_ctrl.sv
`timescale 1ns/1ns
module apf_port_ctrl #(
    parameter int OUT_HALF_DIV = 16
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Control and data channel register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // Transmitter serial input and pacing
    input wire apf_pkg::apf_ser_pins_t ser_in,
    output logic pace_req_out,
    output logic mclk_out,
    output logic cfg_error_out,
    // Receiver serial output and pacing
    input wire logic rx_req_in,
    input wire logic [23:0] left_in,
    input wire logic [23:0] right_in,
    output logic sample_take_out,
    output apf_pkg::apf_ser_pins_t ser_out
);
    import apf_pkg::*;

    localparam int HALT_BOUND = 2 * OUT_HALF_DIV + 4;

    typedef struct packed {
        apf_regs_t regs;
        logic [7:0] rdata;
        apf_ser_pins_t in_s1;
        apf_ser_pins_t in_s2;
        logic prev_bclk;
        logic prev_ws;
        logic [5:0] bit_cnt;
        logic [5:0] det_bits;
        logic signed [23:0] credit;
        logic pace_act;
        logic pace_out;
        logic cfg_err;
        logic rq_s1;
        logic rq_s2;
        apf_out_state_t ost;
        logic [7:0] div;
        logic [5:0] slot;
        logic [23:0] left;
        logic [23:0] right;
        logic take;
        apf_ser_pins_t pins;
    } apf_ctl_state_t;

    apf_ctl_state_t s_q;
    apf_ctl_state_t s_d;
    logic data_mode;
    logic rate_ok;
    logic bit_edge;
    logic rx_act;
    logic running;
    logic tick;
    logic [4:0] pos;
    logic [4:0] msb;
    logic [4:0] sz;
    logic [4:0] k;
    logic [23:0] smp;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        pos = 5'h00;
        msb = 5'h00;
        k = 5'h00;
        smp = 24'h00_0000;
        data_mode = s_q.regs.in_fmt[APF_INF_DATA];
        rate_ok = (s_q.regs.rate <= APF_RATE_TOP_CODE);
        // Registers stay reachable from reset on.
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                APF_ADDR_TX_MODE: s_d.regs.tx_mode = reg_wdata_in;
                APF_ADDR_IN_FMT:
                    s_d.regs.in_fmt = reg_wdata_in & APF_WMASK_IN_FMT;
                APF_ADDR_RATE: s_d.regs.rate = reg_wdata_in;
                APF_ADDR_OUT_FMT:
                    s_d.regs.out_fmt = reg_wdata_in & APF_WMASK_OUT_FMT;
                APF_ADDR_RX_MODE:
                    s_d.regs.rx_mode = reg_wdata_in & APF_WMASK_RX_MODE;
                default: ;
            endcase
        end
        unique case (reg_addr_in)
            APF_ADDR_TX_MODE: s_d.rdata = s_q.regs.tx_mode;
            APF_ADDR_IN_FMT: s_d.rdata = s_q.regs.in_fmt;
            APF_ADDR_RATE: s_d.rdata = s_q.regs.rate;
            APF_ADDR_OUT_FMT: s_d.rdata = s_q.regs.out_fmt;
            APF_ADDR_RX_MODE: s_d.rdata = s_q.regs.rx_mode;
            APF_ADDR_DET_STATUS: s_d.rdata = {s_q.cfg_err, 1'b0, s_q.det_bits};
            default: s_d.rdata = 8'h00;
        endcase

        // Input pins pass two flops; only the second stage is used.
        s_d.in_s1 = ser_in;
        s_d.in_s2 = s_q.in_s1;
        s_d.rq_s1 = rx_req_in;
        s_d.rq_s2 = s_q.rq_s1;
        bit_edge = s_q.in_s2.bclk && !s_q.prev_bclk;
        s_d.prev_bclk = s_q.in_s2.bclk;

        // Bits per word are counted between WS transitions.
        if (bit_edge) begin
            s_d.prev_ws = s_q.in_s2.ws;
            if (s_q.in_s2.ws != s_q.prev_ws) begin
                s_d.det_bits = s_q.bit_cnt;
                s_d.bit_cnt = 6'h01;
            end else if (s_q.bit_cnt != 6'h3F) begin
                s_d.bit_cnt = s_q.bit_cnt + 6'h01;
            end
        end

        // Credit grows at the programmed rate, each bit spends APF_BIT_COST.
        s_d.cfg_err = data_mode && !rate_ok;
        if (!data_mode || !rate_ok) begin
            s_d.credit = '0;
            s_d.pace_act = !data_mode;
        end else begin
            s_d.credit = s_q.credit
                + $signed({13'h0000, apf_rate_kbps(s_q.regs.rate)});
            if (bit_edge) begin
                s_d.credit = s_d.credit - APF_BIT_COST;
            end
            if (s_d.credit > APF_CREDIT_MAX) begin
                s_d.credit = APF_CREDIT_MAX;
            end
            // The source may overrun by its stop latency.
            s_d.pace_act = (s_d.credit > 0);
        end
        s_d.pace_out = s_q.regs.tx_mode[APF_TXM_REQ_POL] ? s_d.pace_act
            : !s_d.pace_act;

        // Receiver serial output.
        rx_act = (s_q.rq_s2 == s_q.regs.rx_mode[APF_RXM_REQ_POL]);
        running = s_q.regs.rx_mode[APF_RXM_EN]
            && !s_q.regs.rx_mode[APF_RXM_PDN]
            && !s_q.regs.rx_mode[APF_RXM_SPDIF];
        tick = (s_q.div == 8'(OUT_HALF_DIV - 1));
        s_d.div = tick ? 8'h00 : s_q.div + 8'h01;
        s_d.take = 1'b0;
        sz = (s_q.regs.out_fmt[APF_OUTF_SIZE_LO+:2] == 2'b10)
            ? 5'd24 : 5'd16;
        unique case (s_q.ost)
            APF_OUT_IDLE: begin
                s_d.pins = '0;
                s_d.slot = 6'h3F;
                if (running) begin
                    s_d.ost = APF_OUT_RUN;
                end
            end
            APF_OUT_RUN: begin
                if (!running) begin
                    s_d.ost = APF_OUT_IDLE;
                end else if (tick && data_mode && !rx_act) begin
                    s_d.ost = APF_OUT_HALT;
                end else if (tick) begin
                    s_d.pins.bclk = !s_q.pins.bclk;
                    // Data moves on the edge opposite the valid edge.
                    if (s_d.pins.bclk == s_q.regs.out_fmt[APF_OUTF_EDGE]) begin
                        s_d.slot = s_q.slot + 6'h01;
                        if (s_d.slot == 6'h00) begin
                            s_d.left = left_in;
                            s_d.right = right_in;
                            s_d.take = 1'b1;
                        end
                        s_d.pins.ws = s_d.slot[5]
                            ^ s_q.regs.out_fmt[APF_OUTF_WS_POL];
                        pos = s_d.slot[4:0];
                        msb = s_q.regs.out_fmt[APF_OUTF_JUST]
                            ? 5'(6'd32 - 6'(sz))
                            : {4'h0, !s_q.regs.out_fmt[APF_OUTF_DELAY]};
                        k = pos - msb;
                        smp = s_d.slot[5] ? s_d.right : s_d.left;
                        s_d.pins.data = (pos >= msb) && (k < sz)
                            && smp[5'(sz - 5'h01 - k)];
                    end
                end
            end
            APF_OUT_HALT: begin
                if (!running) begin
                    s_d.ost = APF_OUT_IDLE;
                end else if (!data_mode || rx_act) begin
                    s_d.ost = APF_OUT_RUN;
                end
            end
            default: s_d.ost = APF_OUT_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
            s_q.regs <= '{APF_RST_TX_MODE, APF_RST_IN_FMT, APF_RST_RATE,
                          APF_RST_OUT_FMT, APF_RST_RX_MODE};
            s_q.pace_act <= 1'b1;
            s_q.slot <= 6'h3F;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Master clock generator
    // ------------------------------------------------------------
    apf_mclk_sel_t mclk_sel;
    assign mclk_sel =
        apf_mclk_sel_t'(s_q.regs.tx_mode[APF_TXM_MCLK_LO+:2]);

    apf_mclk_gen u_mclk (
        .clock_in (clock_in),
        .sys_rst_in (sys_rst_in),
        .sel_in (mclk_sel),
        .block_in (s_q.regs.tx_mode[APF_TXM_SPDIF]),
        .mclk_out (mclk_out)
    );

    assign reg_rdata_out = s_q.rdata;
    assign pace_req_out = s_q.pace_out;
    assign cfg_error_out = s_q.cfg_err;
    assign sample_take_out = s_q.take;
    assign ser_out = s_q.pins;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    logic mclk_on;
    assign mclk_on = (s_q.regs.tx_mode[1:0] != 2'b00)
        && !s_q.regs.tx_mode[APF_TXM_SPDIF];

    a_mclk_spdif_off: assert property (
        s_q.regs.tx_mode[APF_TXM_SPDIF] |=> !mclk_out)
        else $error("master clock runs with S/PDIF input");
    a_mclk_sel_off: assert property (
        s_q.regs.tx_mode[1:0] == 2'b00 |=> !mclk_out)
        else $error("master clock runs with select off");
    a_mclk_toggles: assert property (
        mclk_on && mclk_out |-> ##[1:6] !mclk_out)
        else $error("master clock stuck high");
    a_req_polarity: assert property (
        pace_req_out == ($past(s_q.regs.tx_mode[APF_TXM_REQ_POL])
            ? s_q.pace_act : !s_q.pace_act))
        else $error("pacing request polarity wrong");
    a_bad_rate_idle: assert property (
        (data_mode && !rate_ok)[*2] |-> !s_q.pace_act && cfg_error_out)
        else $error("pacing active at illegal rate");
    a_credit_rate: assert property (
        data_mode && rate_ok && !bit_edge && s_d.credit < APF_CREDIT_MAX
        && !reg_wr_in |=> s_q.credit == $past(s_q.credit)
            + $signed({13'h0000, apf_rate_kbps(s_q.regs.rate)}))
        else $error("credit does not follow rate");
    a_rx_mode_mbz: assert property (
        (s_q.regs.rx_mode & ~APF_WMASK_RX_MODE) == 8'h00)
        else $error("reserved receiver bits set");
    a_halt_clock: assert property (
        s_q.ost == APF_OUT_HALT ##1 s_q.ost == APF_OUT_HALT
        |-> $stable(ser_out.bclk))
        else $error("bit clock moves while halted");
    a_halt_bound: assert property (
        s_q.ost == APF_OUT_RUN && running && data_mode
        && !rx_req_in == s_q.regs.rx_mode[APF_RXM_REQ_POL]
        |-> ##[1:HALT_BOUND] s_q.ost != APF_OUT_RUN)
        else $error("output did not halt in time");
    a_data_edge: assert property (
        $changed(ser_out.data) && s_q.ost == APF_OUT_RUN
        && $stable(s_q.regs.out_fmt)
        |-> ser_out.bclk == s_q.regs.out_fmt[APF_OUTF_EDGE])
        else $error("data changed on valid edge");
    a_det_latch: assert property (
        bit_edge && s_q.in_s2.ws != s_q.prev_ws
        |=> s_q.det_bits == $past(s_q.bit_cnt) && s_q.bit_cnt == 6'h01)
        else $error("word length not latched");
    a_reg_readback: assert property (
        reg_wr_in && reg_addr_in == APF_ADDR_RATE
        ##1 !reg_wr_in && reg_addr_in == APF_ADDR_RATE
        |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("rate register read back wrong");

    c_pace_drop: cover property (data_mode && $fell(s_q.pace_act));
    c_out_halt: cover property (s_q.ost == APF_OUT_HALT);
    c_frame_take: cover property (sample_take_out);
    c_word_det: cover property (s_q.det_bits == 6'h20);

endmodule // apf_port_ctrl

// >>> sim/apf_src_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Paced serial source
// ------------------------------------------------------------
module apf_src_model #(
    parameter int LAG = 8
) (
    // Control
    input wire logic enable_in,
    input wire logic pol_in,
    input wire logic pace_req_in,
    // Serial stream
    output apf_pkg::apf_ser_pins_t ser_out,
    output int bit_cnt_out
);
    import apf_pkg::*;
    int since_off;
    // Clock and data both stand still between bursts.
    initial begin
        ser_out = '0;
        bit_cnt_out = 0;
        since_off = LAG;
        #7;
        forever begin
            if (pace_req_in === pol_in) begin
                since_off = 0;
            end
            if (enable_in && since_off < LAG) begin
                since_off = (pace_req_in === pol_in) ? 0 : since_off + 1;
                #40 ser_out.data = bit_cnt_out[2];
                #40 ser_out.bclk = 1'b1;
                bit_cnt_out++;
                #40 ser_out.ws = bit_cnt_out[5];
                #40 ser_out.bclk = 1'b0;
            end else begin
                #80;
            end
        end
    end
endmodule // apf_src_model

// >>> sim/tb_apf_port_ctrl.sv
`timescale 1ns/1ns
module tb_apf_port_ctrl;
    import apf_pkg::*;
    localparam int HALF = 2;
    logic clock_in, sys_rst_in, reg_wr, rx_req, src_en, src_pol;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic pace_req, mclk, cfg_err, take;
    logic [23:0] left, right;
    apf_ser_pins_t ser_src, ser_dac;
    int src_bits, error_cnt, checks;

    apf_port_ctrl #(.OUT_HALF_DIV(HALF)) apf_port_ctrl_i (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
        .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
        .ser_in(ser_src), .pace_req_out(pace_req), .mclk_out(mclk),
        .cfg_error_out(cfg_err), .rx_req_in(rx_req), .left_in(left),
        .right_in(right), .sample_take_out(take), .ser_out(ser_dac));
    apf_src_model apf_src_model_i (
        .enable_in(src_en), .pol_in(src_pol), .pace_req_in(pace_req),
        .ser_out(ser_src), .bit_cnt_out(src_bits));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_in);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock_in);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock_in);
        reg_addr = a;
        cycles(2);
        chk(reg_rdata, exp);
    endtask
    task automatic cnt_tog(input int n, output int t);
        logic pb;
        t = 0;
        pb = ser_dac.bclk;
        repeat (n) begin
            @(negedge clock_in);
            if (ser_dac.bclk !== pb) t++;
            pb = ser_dac.bclk;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] adr [6] = '{8'h14, 8'h15, 8'h1A, 8'h44, 8'h4A, 8'h33};
        foreach (adr[i]) rd(adr[i], 8'h00);
        wr(APF_ADDR_RX_MODE, 8'hFF);
        wr(APF_ADDR_OUT_FMT, 8'hFF);
        wr(APF_ADDR_RATE, 8'hBF);
        wr(8'h33, 8'hFF);
        rd(APF_ADDR_RX_MODE, 8'hB4);
        rd(APF_ADDR_OUT_FMT, 8'h7F);
        rd(APF_ADDR_RATE, 8'hBF);
        rd(8'h33, 8'h00);
        wr(APF_ADDR_RX_MODE, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_mclk();
        // Select 01 with the S/PDIF input chosen, as a host should.
        logic [7:0] mode [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05};
        int exp_e [5] = '{0, 614, 564, 410, 0};
        int n;
        logic prev;
        for (int s = 0; s < 5; s++) begin
            wr(APF_ADDR_TX_MODE, mode[s]);
            cycles(50);
            n = 0;
            prev = mclk;
            repeat (2500) begin
                @(negedge clock_in);
                if (mclk === 1'b1 && prev === 1'b0) n++;
                prev = mclk;
            end
            chk_rng(n, exp_e[s] - 2, exp_e[s] + 2);
        end
        $display("test mclk done");
    endtask
    task automatic t_pol();
        wr(APF_ADDR_IN_FMT, 8'h00);
        wr(APF_ADDR_TX_MODE, 8'h00);
        cycles(5);
        chk({7'h00, pace_req}, 8'h00);
        wr(APF_ADDR_TX_MODE, 8'h10);
        cycles(5);
        chk({7'h00, pace_req}, 8'h01);
        wr(APF_ADDR_IN_FMT, 8'h80);
        wr(APF_ADDR_RATE, 8'hC0);
        cycles(5);
        chk({6'h00, cfg_err, pace_req}, 8'h02);
        wr(APF_ADDR_RATE, 8'hBF);
        cycles(5);
        chk({7'h00, cfg_err}, 8'h00);
        $display("test polarity done");
    endtask
    task automatic t_pace(input logic [7:0] n, input int exp_b);
        int b0;
        wr(APF_ADDR_RATE, n);
        src_pol = 1'b1;
        src_en = 1'b1;
        cycles(2000);
        b0 = src_bits;
        cycles(20000);
        chk_rng(src_bits - b0, exp_b - 80, exp_b + 80);
        rd(APF_ADDR_DET_STATUS, 8'h20);
        src_en = 1'b0;
        $display("test pacing done");
    endtask
    task automatic t_rx(input logic [7:0] fmt, input int e0, input int e1,
                        input int e2);
        int ones0, ones1, takes, first1;
        logic pb;
        wr(APF_ADDR_OUT_FMT, fmt);
        cycles(600);
        ones0 = 0;
        ones1 = 0;
        takes = 0;
        first1 = 0;
        pb = ser_dac.bclk;
        repeat (1024) begin
            @(negedge clock_in);
            if (take === 1'b1) begin
                takes++;
                if (ser_dac.data === 1'b1) first1++;
            end
            if (ser_dac.bclk !== pb && ser_dac.bclk === ~fmt[2]) begin
                if (ser_dac.data === 1'b1 && ser_dac.ws === 1'b0) ones0++;
                if (ser_dac.data === 1'b1 && ser_dac.ws === 1'b1) ones1++;
            end
            pb = ser_dac.bclk;
        end
        chk_rng(takes, 4, 4);
        chk_rng(ones0, e0, e0);
        chk_rng(ones1, e1, e1);
        chk_rng(first1, e2, e2);
        $display("test output format done");
    endtask
    task automatic t_halt();
        int t;
        wr(APF_ADDR_IN_FMT, 8'h80);
        wr(APF_ADDR_RX_MODE, 8'h30);
        rx_req = 1'b1;
        cycles(300);
        rx_req = 1'b0;
        cnt_tog(140, t);
        chk_rng(t, 0, 64);
        cnt_tog(300, t);
        chk_rng(t, 0, 0);
        rx_req = 1'b1;
        cnt_tog(140, t);
        chk_rng(t, 8, 80);
        wr(APF_ADDR_RX_MODE, 8'hA0);
        cycles(50);
        cnt_tog(300, t);
        chk_rng(t, 0, 0);
        $display("test halt done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    initial begin
        repeat (90000) @(posedge clock_in);
        error_cnt++;
        $display("run timed out");
        give_verdict();
    end
    initial begin
        sys_rst_in = 1'b1;
        {reg_wr, rx_req, src_en, src_pol} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        left = 24'hFF_FFFF;
        right = 24'h00_0000;
        error_cnt = 0;
        checks = 0;
        cycles(8);
        sys_rst_in = 1'b0;
        t_regs();
        t_mclk();
        t_pol();
        t_pace(8'hBF, 614);
        t_pace(8'h5F, 307);
        wr(APF_ADDR_IN_FMT, 8'h00);
        wr(APF_ADDR_RX_MODE, 8'h20);
        t_rx(8'h00, 64, 0, 0);
        t_rx(8'h08, 0, 64, 0);
        t_rx(8'h20, 96, 0, 0);
        t_rx(8'h07, 64, 0, 0);
        t_rx(8'h02, 64, 0, 4);
        t_halt();
        give_verdict();
    end
endmodule // tb_apf_port_ctrl
